// [hdl/abu_consts.svh]
`ifndef ABU_CONSTS_SVH
`define ABU_CONSTS_SVH
// Register bus geometry
`define ABU_AW 8
`define ABU_DW 32
// Register byte offsets
`define ABU_OFS_SC 8'h00
`define ABU_OFS_AH 8'h04
`define ABU_OFS_AL 8'h08
`define ABU_OFS_LP 8'h0c
`define ABU_OFS_FC 8'h10
`define ABU_OFS_IS 8'h14
`define ABU_OFS_IM 8'h18
// Field positions
`define ABU_BIT_BE 7
`define ABU_BIT_BA 6
`define ABU_BIT_LP 1
`define ABU_BIT_FC 7
`define ABU_IRQ_W 2
`define ABU_IRQ_ENTER 0
`define ABU_IRQ_LEAVE 1
// Reset values and vectors
`define ABU_ADDR_RST 8'h00
`define ABU_VEC_USER 16'hfffc
`define ABU_VEC_MON 16'hfefc
// Bus responses
`define ABU_RESP_OK 2'b00
`define ABU_RESP_ERR 2'b10
`endif

// [hdl/abu_pkg.sv]
package abu_pkg;
  // Break sequencing states
  typedef enum logic [1:0] {
    ABU_IDLE,
    ABU_PENDING,
    ABU_ACTIVE
  } abu_state_e;
endpackage

// [hdl/abu_regbus_if.sv]
`timescale 1ns/1ps
`include "abu_consts.svh"
interface abu_regbus_if;
  logic wrEn;
  logic [`ABU_AW-1:0] wrAddr;
  logic [7:0] wrData;
  logic wrLane;
  logic wrHit;
  logic rdEn;
  logic [`ABU_AW-1:0] rdAddr;
  logic [7:0] rdData;
  logic rdHit;
  modport bus (output wrEn, wrAddr, wrData, wrLane, rdEn, rdAddr,
               input wrHit, rdData, rdHit);
  modport regs (input wrEn, wrAddr, wrData, wrLane, rdEn, rdAddr,
                output wrHit, rdData, rdHit);
endinterface

// [hdl/abu_axil_slave.sv]
`timescale 1ns/1ps
`include "abu_consts.svh"
module abu_axil_slave
  import abu_pkg::*;
(
  input wire logic sys_clk, // Bus clock
  input wire logic rstn, // Sync reset, active low
  input wire logic [`ABU_AW-1:0] awaddr, // Write address
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [`ABU_DW-1:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Byte enables
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  output logic [1:0] bresp, // Write response
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  input wire logic [`ABU_AW-1:0] araddr, // Read address
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  output logic [`ABU_DW-1:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  output logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  abu_regbus_if.bus rb // Register file side
);
  logic awFull, wFull;
  logic [`ABU_AW-1:0] awAddrQ;
  logic [7:0] wDataQ;
  logic wLaneQ;
  wire awTake = awvalid && awready;
  wire wTake = wvalid && wready;
  wire bDone = bvalid && bready;
  wire next_awFull = awFull ? !bDone : awTake;
  wire next_wFull = wFull ? !bDone : wTake;
  // Write fires once both halves are held and no answer is pending
  wire doWrite = awFull && wFull && !bvalid;
  assign rb.wrEn = doWrite;
  assign rb.wrAddr = awAddrQ;
  assign rb.wrData = wDataQ;
  assign rb.wrLane = wLaneQ;
  assign rb.rdEn = arvalid && arready;
  assign rb.rdAddr = araddr;

  // Address and data accepted in either order, then held
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      awFull <= 1'b0;
      wFull <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      awAddrQ <= '0;
      wDataQ <= '0;
      wLaneQ <= 1'b0;
    end else begin
      awFull <= next_awFull;
      wFull <= next_wFull;
      awready <= !next_awFull;
      wready <= !next_wFull;
      if (awTake) awAddrQ <= awaddr;
      if (wTake) wDataQ <= wdata[7:0];
      if (wTake) wLaneQ <= wstrb[0]; // Only the low lane carries data
    end
  end

  // Responses; an unmapped address answers with an error
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      bvalid <= 1'b0;
      bresp <= `ABU_RESP_OK;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= `ABU_RESP_OK;
    end else begin
      if (doWrite) begin
        bvalid <= 1'b1;
        bresp <= rb.wrHit ? `ABU_RESP_OK : `ABU_RESP_ERR;
      end else if (bDone) begin
        bvalid <= 1'b0;
      end
      if (rb.rdEn) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= {24'h000000, rb.rdData};
        rresp <= rb.rdHit ? `ABU_RESP_OK : `ABU_RESP_ERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end else if (!rvalid) begin
        arready <= 1'b1;
      end
    end
  end
endmodule

// [hdl/abu_top.sv]
// How it works
// - An enabled match on the 16-bit break address raises the request.
// - Only program-counter addresses take part in the comparison.
// - After a request the opcode load waits for the instruction to end.
// - Break vector is fffc/fffd in user mode, fefc/fefd in monitor mode.
// - A match in an instruction's last cycle starts the break at once.
// - A return-from-interrupt in the break routine ends the break state.
// - Writing one to the break-active bit causes a break like a match.
// - The timer counter is held stopped during a break.
// - The watchdog is off in a break while test high voltage is on reset.
// - Break enable, bit 7 of status/control, is R/W and clears on reset.
// - Break active sets on a match; reset or a zero write clears it.
// - The high and low break address registers are cleared by reset.
// - Low-power-exit marks a break out of stop/wait; zero writes clear it.
// - A break ends stop mode and sets the low-power-exit flag.
// - With breaks enabled the comparison keeps working in wait mode.
// - In a break other units clear flags only with flag-clear-enable set.
//
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "abu_consts.svh"
module abu_top
  import abu_pkg::*;
(
  input wire logic sys_clk, // Bus clock, 50 MHz
  input wire logic rstn, // Sync reset, active low
  input wire logic [`ABU_AW-1:0] awaddr, // Write address
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [`ABU_DW-1:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Byte enables
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  output logic [1:0] bresp, // Write response
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  input wire logic [`ABU_AW-1:0] araddr, // Read address
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  output logic [`ABU_DW-1:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  output logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  input wire logic [15:0] cpuAddr, // Internal address bus
  input wire logic cpuPcValid, // Address comes from program counter
  input wire logic instrLastCycle, // Last cycle of current instruction
  input wire logic rtiDone, // Return-from-interrupt executed
  input wire logic monitorMode, // Device in monitor mode
  input wire logic stopMode, // Device in stop mode
  input wire logic waitMode, // Device in wait mode
  input wire logic testHighVoltage, // Test voltage seen on reset pin
  output logic breakpointRequest, // Request to integration logic
  output logic loadSwiOpcode, // Pulse: load software-interrupt opcode
  output logic [15:0] vectorAddr, // Break vector high-byte address
  output logic stopExit, // Pulse: leave stop mode
  output logic timerStop, // Hold timer counter
  output logic watchdogDisable, // Disable watchdog
  output logic flagClearAllowed, // Other units may clear flags
  output logic irq // Level interrupt
);
  abu_regbus_if rb ();
  abu_state_e state, next_state;
  logic breakEnable, breakActiveBit, lowpowerExitFlag, flagClearEnable;
  logic [7:0] addrHigh, addrLow;
  logic [`ABU_IRQ_W-1:0] irqStatus, irqMask;
  logic tst1, tst2, tst3, tstLevel;

  abu_axil_slave abu_axil_slave_inst (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .rb(rb.bus)
  );

  // Write decode; data sits in the low byte lane
  wire wrGo = rb.wrEn && rb.wrLane;
  wire wrSc = wrGo && (rb.wrAddr == `ABU_OFS_SC);
  wire wrAh = wrGo && (rb.wrAddr == `ABU_OFS_AH);
  wire wrAl = wrGo && (rb.wrAddr == `ABU_OFS_AL);
  wire wrLp = wrGo && (rb.wrAddr == `ABU_OFS_LP);
  wire wrFc = wrGo && (rb.wrAddr == `ABU_OFS_FC);
  wire wrIm = wrGo && (rb.wrAddr == `ABU_OFS_IM);
  wire rdIs = rb.rdEn && (rb.rdAddr == `ABU_OFS_IS);

  // Address map hits for the response code
  function automatic logic mapped(input logic [`ABU_AW-1:0] a);
    mapped = (a == `ABU_OFS_SC) || (a == `ABU_OFS_AH) ||
             (a == `ABU_OFS_AL) || (a == `ABU_OFS_LP) ||
             (a == `ABU_OFS_FC) || (a == `ABU_OFS_IS) ||
             (a == `ABU_OFS_IM);
  endfunction
  assign rb.wrHit = mapped(rb.wrAddr);
  assign rb.rdHit = mapped(rb.rdAddr);

  // Read mux; unused bits read as zero
  wire [7:0] scRead = {breakEnable, breakActiveBit, 6'h00};
  wire [7:0] lpRead = {6'h00, lowpowerExitFlag, 1'b0};
  wire [7:0] fcRead = {flagClearEnable, 7'h00};
  wire [7:0] isRead = {6'h00, irqStatus};
  wire [7:0] imRead = {6'h00, irqMask};
  assign rb.rdData = (rb.rdAddr == `ABU_OFS_SC) ? scRead :
                     (rb.rdAddr == `ABU_OFS_AH) ? addrHigh :
                     (rb.rdAddr == `ABU_OFS_AL) ? addrLow :
                     (rb.rdAddr == `ABU_OFS_LP) ? lpRead :
                     (rb.rdAddr == `ABU_OFS_FC) ? fcRead :
                     (rb.rdAddr == `ABU_OFS_IS) ? isRead :
                     (rb.rdAddr == `ABU_OFS_IM) ? imRead : 8'h00;

  // Break sources; comparison is not gated by wait mode
  wire swBreak = wrSc && rb.wrData[`ABU_BIT_BA];
  wire pcMatch = breakEnable && cpuPcValid &&
                 (cpuAddr == {addrHigh, addrLow});
  wire trigger = pcMatch || swBreak;

  // Break sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      ABU_IDLE: begin
        if (trigger) begin
          next_state = instrLastCycle ? ABU_ACTIVE : ABU_PENDING;
        end
      end
      ABU_PENDING: begin
        if (instrLastCycle) next_state = ABU_ACTIVE;
      end
      ABU_ACTIVE: begin
        if (rtiDone) next_state = ABU_IDLE;
      end
    endcase
  end
  wire enter = (state != ABU_ACTIVE) && (next_state == ABU_ACTIVE);
  wire leave = (state == ABU_ACTIVE) && (next_state == ABU_IDLE);
  wire lowPowerWake = enter && (stopMode || waitMode);

  // Test voltage comes from a pin; accept it once two stages agree
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      tst1 <= 1'b0;
      tst2 <= 1'b0;
      tst3 <= 1'b0;
      tstLevel <= 1'b0;
    end else begin
      tst1 <= testHighVoltage;
      tst2 <= tst1;
      tst3 <= tst2;
      if (tst2 == tst3) tstLevel <= tst3;
    end
  end

  // Control registers; a hardware set beats a same-cycle clear
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      breakEnable <= 1'b0;
      breakActiveBit <= 1'b0;
      addrHigh <= `ABU_ADDR_RST;
      addrLow <= `ABU_ADDR_RST;
      flagClearEnable <= 1'b0;
      irqMask <= '0;
    end else begin
      if (wrSc) breakEnable <= rb.wrData[`ABU_BIT_BE];
      if (trigger) breakActiveBit <= 1'b1;
      else if (wrSc) breakActiveBit <= rb.wrData[`ABU_BIT_BA];
      if (wrAh) addrHigh <= rb.wrData;
      if (wrAl) addrLow <= rb.wrData;
      if (wrFc) flagClearEnable <= rb.wrData[`ABU_BIT_FC];
      if (wrIm) irqMask <= rb.wrData[`ABU_IRQ_W-1:0];
    end
  end

  // Low-power exit flag; writing one has no effect
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      lowpowerExitFlag <= 1'b0;
    end else if (lowPowerWake) begin
      lowpowerExitFlag <= 1'b1;
    end else if (wrLp && !rb.wrData[`ABU_BIT_LP]) begin
      lowpowerExitFlag <= 1'b0;
    end
  end

  // Sticky events, cleared by reading; new events win over the clear
  wire [`ABU_IRQ_W-1:0] events = {leave, enter};
  wire [`ABU_IRQ_W-1:0] next_irqStatus =
    (rdIs ? '0 : irqStatus) | events;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      irqStatus <= '0;
      irq <= 1'b0;
    end else begin
      irqStatus <= next_irqStatus;
      irq <= |(next_irqStatus & irqMask);
    end
  end

  // State and the outputs toward the rest of the device
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state <= ABU_IDLE;
      breakpointRequest <= 1'b0;
      loadSwiOpcode <= 1'b0;
      vectorAddr <= `ABU_VEC_USER;
      stopExit <= 1'b0;
      timerStop <= 1'b0;
      watchdogDisable <= 1'b0;
      flagClearAllowed <= 1'b1;
    end else begin
      state <= next_state;
      breakpointRequest <= (next_state != ABU_IDLE);
      loadSwiOpcode <= enter;
      if (enter) begin
        vectorAddr <= monitorMode ? `ABU_VEC_MON : `ABU_VEC_USER;
      end
      stopExit <= enter && stopMode;
      timerStop <= (next_state == ABU_ACTIVE);
      watchdogDisable <= (next_state == ABU_ACTIVE) && tstLevel;
      // Flags of other units stay frozen while the break routine looks, unless flagClearEnable is set
      flagClearAllowed <= (next_state != ABU_ACTIVE) ||
                          flagClearEnable;
    end
  end

  // Checks on the break sequence
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_break_start;
    loadSwiOpcode && timerStop && breakpointRequest;
  endsequence

  sequence s_break_end;
    !breakpointRequest && !timerStop && !watchdogDisable;
  endsequence

  property p_match_req;
    pcMatch |=> breakpointRequest && breakActiveBit;
  endproperty
  a_match_req: assert property (p_match_req)
    else $error("match did not raise request");

  property p_pc_only;
    (state == ABU_IDLE) && !cpuPcValid && !swBreak |=> !breakpointRequest;
  endproperty
  a_pc_only: assert property (p_pc_only)
    else $error("request without program counter match");

  property p_swi_load;
    (state == ABU_PENDING) && instrLastCycle |=> s_break_start;
  endproperty
  a_swi_load: assert property (p_swi_load)
    else $error("opcode load missing at instruction end");

  property p_vector;
    loadSwiOpcode |-> vectorAddr ==
      ($past(monitorMode) ? `ABU_VEC_MON : `ABU_VEC_USER);
  endproperty
  a_vector: assert property (p_vector)
    else $error("wrong break vector");

  property p_immediate;
    (state == ABU_IDLE) && pcMatch && instrLastCycle |=>
      s_break_start ##0 (state == ABU_ACTIVE);
  endproperty
  a_immediate: assert property (p_immediate)
    else $error("break not started at once");

  property p_rti_end;
    (state == ABU_ACTIVE) && rtiDone |=> s_break_end;
  endproperty
  a_rti_end: assert property (p_rti_end)
    else $error("break state not ended by return");

  property p_sw_break;
    swBreak |=> breakActiveBit && breakpointRequest;
  endproperty
  a_sw_break: assert property (p_sw_break)
    else $error("software break ignored");

  property p_timer_hold;
    (state == ABU_ACTIVE) && !rtiDone |=>
      timerStop ##1 (timerStop == breakpointRequest);
  endproperty
  a_timer_hold: assert property (p_timer_hold)
    else $error("timer ran during break");

  property p_watchdog;
    (state == ABU_ACTIVE) && $past(tstLevel) |-> watchdogDisable;
  endproperty
  a_watchdog: assert property (p_watchdog)
    else $error("watchdog left running");

  property p_enable_clr;
    wrSc && !rb.wrData[`ABU_BIT_BE] |=> !breakEnable ##0 !pcMatch;
  endproperty
  a_enable_clr: assert property (p_enable_clr)
    else $error("break enable not cleared");

  property p_active_clr;
    wrSc && !rb.wrData[`ABU_BIT_BA] && !pcMatch |=> !breakActiveBit;
  endproperty
  a_active_clr: assert property (p_active_clr)
    else $error("break active not cleared");

  property p_lp_clr;
    wrLp && !rb.wrData[`ABU_BIT_LP] && !lowPowerWake |=> !lowpowerExitFlag;
  endproperty
  a_lp_clr: assert property (p_lp_clr)
    else $error("low-power flag not cleared");

  property p_stop_wake;
    enter && stopMode |=> stopExit && lowpowerExitFlag ##1 !stopExit;
  endproperty
  a_stop_wake: assert property (p_stop_wake)
    else $error("stop not left on break");

  property p_wait_cmp;
    waitMode && pcMatch && (state == ABU_IDLE) |=> breakpointRequest;
  endproperty
  a_wait_cmp: assert property (p_wait_cmp)
    else $error("comparison dead in wait mode");

  property p_flag_guard;
    (next_state == ABU_ACTIVE) && !flagClearEnable |=> !flagClearAllowed;
  endproperty
  a_flag_guard: assert property (p_flag_guard)
    else $error("flags clearable during break");
endmodule

// [testbench/abu_cpu_model.sv]
`timescale 1ns/1ps
module abu_cpu_model
  import abu_pkg::*;
(
  input wire logic sys_clk, // Bus clock
  input wire logic rstn, // Sync reset, active low
  input wire logic run, // Let the program run
  input wire logic [15:0] pcStart, // First program address
  input wire logic [15:0] dataAddr, // Operand address on other cycles
  input wire logic [1:0] instrLen, // Cycles per instruction, 1 to 3
  input wire logic loadSwiOpcode, // Opcode insert from the unit
  output logic [15:0] cpuAddr, // Internal address bus
  output logic cpuPcValid, // Address is the program counter
  output logic instrLastCycle, // Last cycle of an instruction
  output logic rtiDone // Return from the break routine
);
  logic [15:0] pc;
  logic [1:0] phase;
  logic [5:0] brkCnt;
  logic inBrk;
  // Fetch shows the PC; operand cycles show a data address, not the PC
  assign cpuPcValid = run && !inBrk && phase == 2'h0;
  assign cpuAddr = cpuPcValid ? pc : dataAddr;
  assign instrLastCycle = run && phase == instrLen - 2'h1;
  // Break routine has a fixed length so the bench can act inside it
  always_ff @(posedge sys_clk) begin
    if (!rstn || !run) begin
      pc <= pcStart;
      phase <= 2'h0;
      inBrk <= 1'b0;
      brkCnt <= 6'h0;
      rtiDone <= 1'b0;
    end else begin
      rtiDone <= 1'b0;
      phase <= instrLastCycle ? 2'h0 : phase + 2'h1;
      if (instrLastCycle && !inBrk)
        pc <= pc + 16'h1;
      if (loadSwiOpcode) begin
        inBrk <= 1'b1;
        brkCnt <= 6'h0;
      end else if (inBrk) begin
        brkCnt <= brkCnt + 6'h1;
        if (brkCnt == 6'h28) begin
          inBrk <= 1'b0;
          rtiDone <= 1'b1;
        end
      end
    end
  end
endmodule

// [testbench/abu_bench.sv]
`timescale 1ns/1ps
`include "abu_consts.svh"
module abu_bench
  import abu_pkg::*;
;
  logic sys_clk = 1'b0, rstn = 1'b0, reqQ = 1'b0;
  logic [`ABU_AW-1:0] awaddr = '0, araddr = '0;
  // Response readies stay high, so back-to-back calls never re-drive them
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1;
  logic arvalid = 1'b0, rready = 1'b1;
  logic [`ABU_DW-1:0] wdata = '0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, instrLen = 2'h1;
  logic [15:0] cpuAddr, vectorAddr, pcStart = '0, dataAddr = '0;
  logic cpuPcValid, instrLastCycle, rtiDone, run = 1'b0;
  logic monitorMode = 1'b0, stopMode = 1'b0, waitMode = 1'b0;
  logic testHighVoltage = 1'b0;
  logic breakpointRequest, loadSwiOpcode, stopExit, timerStop;
  logic watchdogDisable, flagClearAllowed, irq;
  int numErrors = 0, checked = 0, cyc = 0, tReq = 0, tLoad = 0, nStop = 0;

  abu_top abu_top_inst (.sys_clk(sys_clk), .rstn(rstn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .cpuAddr(cpuAddr), .cpuPcValid(cpuPcValid),
    .instrLastCycle(instrLastCycle), .rtiDone(rtiDone),
    .monitorMode(monitorMode), .stopMode(stopMode), .waitMode(waitMode),
    .testHighVoltage(testHighVoltage),
    .breakpointRequest(breakpointRequest), .loadSwiOpcode(loadSwiOpcode),
    .vectorAddr(vectorAddr), .stopExit(stopExit), .timerStop(timerStop),
    .watchdogDisable(watchdogDisable),
    .flagClearAllowed(flagClearAllowed), .irq(irq));

  abu_cpu_model abu_cpu_model_inst (.sys_clk(sys_clk), .rstn(rstn),
    .run(run), .pcStart(pcStart), .dataAddr(dataAddr),
    .instrLen(instrLen), .loadSwiOpcode(loadSwiOpcode),
    .cpuAddr(cpuAddr), .cpuPcValid(cpuPcValid),
    .instrLastCycle(instrLastCycle), .rtiDone(rtiDone));

  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  // Edge stamps of request rise and opcode insert; pulses are too short
  // to be caught reliably by the sequencing code
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    reqQ <= breakpointRequest;
    if (breakpointRequest === 1'b1 && reqQ !== 1'b1)
      tReq <= cyc;
    if (loadSwiOpcode === 1'b1)
      tLoad <= cyc;
    if (stopExit === 1'b1)
      nStop <= nStop + 1;
    if (cyc == 3000) begin
      numErrors++;
      printVerdict();
    end
  end

  task automatic printVerdict();
    $display("checks %0d mismatches %0d", checked, numErrors);
    if (numErrors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      numErrors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk(bresp, er);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                    input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arready)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    chk(rdata[7:0], exp);
    chk(rresp, er);
  endtask

  // One break: run until inserted, check state, clear, wait for return
  task automatic brk(input logic [1:0] len, input logic [15:0] vec,
    input logic wd, input logic fca, input logic [7:0] sc,
    input logic [7:0] lp);
    instrLen <= len;
    run <= 1'b1;
    while (loadSwiOpcode !== 1'b1)
      @(posedge sys_clk);
    chk(breakpointRequest, 1'b1);
    chk(vectorAddr, vec);
    @(posedge sys_clk);
    chk(timerStop, 1'b1);
    chk(watchdogDisable, wd);
    chk(flagClearAllowed, fca);
    rd(`ABU_OFS_SC, sc, `ABU_RESP_OK);
    wr(`ABU_OFS_SC, 8'h00, `ABU_RESP_OK);
    rd(`ABU_OFS_LP, lp, `ABU_RESP_OK);
    while (breakpointRequest !== 1'b0)
      @(posedge sys_clk);
    chk(timerStop, 1'b0);
    chk(flagClearAllowed, 1'b1);
    run <= 1'b0;
    @(posedge sys_clk);
  endtask

  initial begin
    logic [7:0] ofs [5];
    ofs = '{`ABU_OFS_SC, `ABU_OFS_AH, `ABU_OFS_AL, `ABU_OFS_LP, `ABU_OFS_FC};
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    // Reset values and register access
    foreach (ofs[i])
      rd(ofs[i], 8'h00, `ABU_RESP_OK);
    chk(vectorAddr, `ABU_VEC_USER);
    rd(8'h1c, 8'h00, `ABU_RESP_ERR);
    wr(8'h1c, 8'h55, `ABU_RESP_ERR);
    wr(`ABU_OFS_AH, 8'h12, `ABU_RESP_OK);
    wr(`ABU_OFS_AL, 8'h34, `ABU_RESP_OK);
    rd(`ABU_OFS_AH, 8'h12, `ABU_RESP_OK);
    rd(`ABU_OFS_AL, 8'h34, `ABU_RESP_OK);
    wr(`ABU_OFS_IM, 8'h03, `ABU_RESP_OK);
    wr(`ABU_OFS_SC, 8'h80, `ABU_RESP_OK);
    rd(`ABU_OFS_SC, 8'h80, `ABU_RESP_OK);
    $display("test registers done");
    // Operand address equal to the break address must not break
    testHighVoltage <= 1'b1;
    dataAddr <= 16'h1234;
    pcStart <= 16'h1240;
    instrLen <= 2'h3;
    run <= 1'b1;
    repeat (30) @(posedge sys_clk);
    chk(breakpointRequest, 1'b0);
    run <= 1'b0;
    pcStart <= 16'h1230;
    @(posedge sys_clk);
    // Match in the first of three cycles, user mode
    brk(2'h3, `ABU_VEC_USER, 1'b1, 1'b0, 8'hc0, 8'h00);
    chk(16'(tLoad - tReq), 16'h2);
    chk(irq, 1'b1);
    rd(`ABU_OFS_IS, 8'h03, `ABU_RESP_OK);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'b0);
    $display("test address break done");
    // One-cycle instructions: match in the last cycle, monitor, wait
    testHighVoltage <= 1'b0;
    monitorMode <= 1'b1;
    waitMode <= 1'b1;
    pcStart <= 16'h1234;
    wr(`ABU_OFS_SC, 8'h80, `ABU_RESP_OK);
    brk(2'h1, `ABU_VEC_MON, 1'b0, 1'b0, 8'hc0, 8'h02);
    chk(16'(tLoad - tReq), 16'h0);
    wr(`ABU_OFS_LP, 8'h00, `ABU_RESP_OK);
    rd(`ABU_OFS_LP, 8'h00, `ABU_RESP_OK);
    rd(`ABU_OFS_IS, 8'h03, `ABU_RESP_OK);
    $display("test immediate break done");
    // Software break out of stop, flags clearable, interrupt masked
    monitorMode <= 1'b0;
    waitMode <= 1'b0;
    stopMode <= 1'b1;
    pcStart <= 16'h1000;
    wr(`ABU_OFS_IM, 8'h00, `ABU_RESP_OK);
    wr(`ABU_OFS_FC, 8'h80, `ABU_RESP_OK);
    wr(`ABU_OFS_SC, 8'h40, `ABU_RESP_OK);
    brk(2'h2, `ABU_VEC_USER, 1'b0, 1'b1, 8'h40, 8'h02);
    chk(16'(nStop), 16'h1);
    chk(irq, 1'b0);
    rd(`ABU_OFS_IS, 8'h03, `ABU_RESP_OK);
    $display("test software break done");
    printVerdict();
  end
endmodule
